// File: rtl/complement_decrement_branch_exec.sv
`timescale 1ns/1ps
// How it works
// - Opcode 00 1001 dfff ffff inverts the addressed file register.
// - File address is seven bits 00h to 7Fh, destination one bit.
// - Destination 0 writes the accumulator, 1 writes the file register.
// - Opcode 00 0011 dfff ffff subtracts one from the file register.
// - Plain decrement sets zero flag on a zero result, else clears it.
// - Opcode 00 1011 dfff ffff decrements and leaves all status alone.
// - A zero skip result discards the next word as a one-cycle nop.
// - Opcode 11 kkkk kkkk kkkk loads k into program counter 11:0.
// - The jump takes two cycles, flushing the fetched next word.
module complement_decrement_branch_exec (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          insn_valid,
  input  wire logic [exec_pkg::INSN_W-1:0]   insn,
  input  wire logic [exec_pkg::DATA_W-1:0]   file_rdata,
  output logic [exec_pkg::ADDR_W-1:0]        file_addr,
  output logic [exec_pkg::DATA_W-1:0]        file_wdata,
  output logic                               file_we,
  output logic [exec_pkg::DATA_W-1:0]        acc_wdata,
  output logic                               acc_we,
  output logic                               zero_flag,
  output logic                               zero_we,
  output logic [exec_pkg::PC_W-1:0]          pc_target,
  output logic                               pc_load,
  output logic                               flush,
  output logic                               busy,
  output logic                               unknown_insn
);
  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  op_decode_if dec ();

  op_decoder u_dec (
    .insn (insn),
    .dec  (dec)
  );

  typedef enum logic {
    st_exec,
    st_flush
  } state_e;

  state_e                      state_q;
  logic                        take;
  logic                        is_inv;
  logic                        is_dec;
  logic                        is_skip;
  logic                        is_jump;
  logic                        is_unknown;
  logic                        is_file_op;
  logic                        sets_zero;
  logic                        to_acc;
  logic                        to_file;
  logic [exec_pkg::DATA_W-1:0] inv_result;
  logic [exec_pkg::DATA_W-1:0] dec_result;
  logic [exec_pkg::DATA_W-1:0] result;
  logic                        res_zero;
  logic                        skip_taken;
  logic                        drop_next;

  // Word after a jump or a taken skip is dropped here
  assign take       = insn_valid && (state_q == st_exec) && dec.hit;
  assign is_unknown = insn_valid && (state_q == st_exec) && !dec.hit;

  assign is_inv  = take && (dec.op == exec_pkg::invert_file_op);
  assign is_dec  = take && (dec.op == exec_pkg::decrement_file_op);
  assign is_skip = take && (dec.op == exec_pkg::decrement_skip_zero_op);
  assign is_jump = take && (dec.op == exec_pkg::unconditional_jump_op);

  assign is_file_op = is_inv || is_dec || is_skip;
  assign sets_zero  = is_inv || is_dec;
  assign to_acc     = is_file_op && (dec.dest == exec_pkg::DEST_ACC);
  assign to_file    = is_file_op && (dec.dest != exec_pkg::DEST_ACC);

  ////////////////////////////////////////////////////////////////////////////
  // Operation results
  assign inv_result = ~file_rdata;
  assign dec_result = file_rdata - exec_pkg::ONE_BYTE;

  always_comb begin
    if (dec.op == exec_pkg::invert_file_op) begin
      result = inv_result;
    end else begin
      result = dec_result;
    end
  end

  assign res_zero   = (result == exec_pkg::ZERO_BYTE);
  assign skip_taken = is_skip && res_zero;
  assign drop_next  = is_jump || skip_taken;

  ////////////////////////////////////////////////////////////////////////////
  // Second cycle of jump or taken skip
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= st_exec;
    end else begin
      case (state_q)
        st_exec: begin
          if (drop_next) begin
            state_q <= st_flush;
          end
        end
        st_flush: begin
          // Dropped slot lasts exactly one cycle
          state_q <= st_exec;
        end
        default: begin
          state_q <= st_exec;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flush <= 1'b0;
    end else begin
      flush <= drop_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= drop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      file_addr <= '0;
    end else if (is_file_op) begin
      file_addr <= dec.addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      file_wdata <= exec_pkg::ZERO_BYTE;
    end else if (to_file) begin
      file_wdata <= result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      file_we <= 1'b0;
    end else begin
      file_we <= to_file;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator write back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_wdata <= exec_pkg::ZERO_BYTE;
    end else if (to_acc) begin
      acc_wdata <= result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_we <= 1'b0;
    end else begin
      acc_we <= to_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag: skip variant leaves it alone
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zero_flag <= 1'b0;
    end else if (sets_zero) begin
      zero_flag <= res_zero;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zero_we <= 1'b0;
    end else begin
      zero_we <= sets_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter load
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_target <= exec_pkg::PC_RST;
    end else if (is_jump) begin
      pc_target <= dec.target;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_load <= 1'b0;
    end else begin
      pc_load <= is_jump;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Words outside the four handled here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unknown_insn <= 1'b0;
    end else begin
      unknown_insn <= is_unknown;
    end
  end
endmodule // complement_decrement_branch_exec

// File: rtl/exec_pkg.sv
package exec_pkg;
  localparam int          INSN_W       = 14;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          PC_W         = 12;
  localparam int          OPC_LO       = 8;
  localparam int          OPC_HI       = 13;
  localparam int          DEST_BIT     = 7;
  localparam int          JMP_LO       = 12;
  localparam logic [5:0]  INVERT_OPC   = 6'h09;
  localparam logic [5:0]  DECR_OPC     = 6'h03;
  localparam logic [5:0]  DECR_SKZ_OPC = 6'h0B;
  localparam logic [1:0]  JUMP_OPC     = 2'h3;
  localparam logic [ADDR_W-1:0] FILE_ADDR_MAX = 7'h7F;
  localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE      = 8'h01;
  localparam logic [PC_W-1:0]   PC_RST        = 12'h000;
  localparam logic              DEST_ACC      = 1'b0;

  typedef enum logic [1:0] {
    invert_file_op,
    decrement_file_op,
    decrement_skip_zero_op,
    unconditional_jump_op
  } op_e;
endpackage

// File: rtl/op_decode_if.sv
`timescale 1ns/1ps
interface op_decode_if;
  logic                                hit;
  exec_pkg::op_e                       op;
  logic                                dest;
  logic [exec_pkg::ADDR_W-1:0]         addr;
  logic [exec_pkg::PC_W-1:0]           target;

  modport decoder (output hit, op, dest, addr, target);
  modport user    (input  hit, op, dest, addr, target);
endinterface

// File: rtl/op_decoder.sv
`timescale 1ns/1ps
module op_decoder (
  input  wire logic [exec_pkg::INSN_W-1:0] insn,
  op_decode_if.decoder                     dec
);
  logic [5:0] opc;

  assign opc         = insn[exec_pkg::OPC_HI:exec_pkg::OPC_LO];
  assign dec.dest    = insn[exec_pkg::DEST_BIT];
  assign dec.addr    = insn[exec_pkg::ADDR_W-1:0];
  assign dec.target  = insn[exec_pkg::PC_W-1:0];

  always_comb begin
    dec.hit = 1'b1;
    dec.op  = exec_pkg::invert_file_op;
    if (opc[5:4] == exec_pkg::JUMP_OPC) begin
      dec.op = exec_pkg::unconditional_jump_op;
    end else if (opc == exec_pkg::INVERT_OPC) begin
      dec.op = exec_pkg::invert_file_op;
    end else if (opc == exec_pkg::DECR_OPC) begin
      dec.op = exec_pkg::decrement_file_op;
    end else if (opc == exec_pkg::DECR_SKZ_OPC) begin
      dec.op = exec_pkg::decrement_skip_zero_op;
    end else begin
      dec.hit = 1'b0;
    end
  end
endmodule // op_decoder

// File: tb/file_reg_model.sv
`timescale 1ns/1ps
module file_reg_model (
  input  wire logic       mclk,
  input  wire logic [6:0] raddr,
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
  assign rdata = mem[raddr];
  always @(posedge mclk) if (we) mem[waddr] <= wdata;
endmodule // file_reg_model

// File: tb/exec_sva.sv
`timescale 1ns/1ps
module exec_sva (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0]  file_rdata,
  input wire logic        file_we,
  input wire logic        acc_we,
  input wire logic [7:0]  acc_wdata,
  input wire logic        zero_flag,
  input wire logic        zero_we,
  input wire logic [11:0] pc_target,
  input wire logic        pc_load,
  input wire logic        flush,
  input wire logic        busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire       go = insn_valid && !flush;
  wire [5:0] g  = go ? insn[13:8] : 6'h3F;
  a_inv_acc: assert property (g == 6'h09 && !insn[7] |=> acc_we
    && acc_wdata == ~$past(file_rdata)) else $error("invert value");
  a_inv_zero: assert property (g == 6'h09 |=> zero_we
    && zero_flag == ($past(file_rdata) == 8'hFF)) else $error("invert zero");
  a_dest_file: assert property (insn[7] && g inside {6'h09, 6'h03, 6'h0B}
    |=> file_we && !acc_we) else $error("destination");
  a_dec_zero: assert property (g == 6'h03 |=> zero_we
    && zero_flag == ($past(file_rdata) == 8'h01)) else $error("dec zero");
  a_skip_status: assert property (g == 6'h0B |=> !zero_we)
    else $error("skip status");
  a_skip_taken: assert property (g == 6'h0B && file_rdata == 8'h01
    |=> flush && busy) else $error("skip flush");
  a_jump_load: assert property (go && insn[13:12] == 2'h3 |=> pc_load
    && flush && busy && pc_target == $past(insn[11:0])) else $error("jump");
  a_flush_drop: assert property (flush |=> !(acc_we || file_we
    || pc_load || zero_we)) else $error("flushed word ran");
  cover property (g == 6'h0B ##1 flush);
  cover property (pc_load);
  cover property (zero_we && zero_flag);
endmodule // exec_sva
bind complement_decrement_branch_exec exec_sva i_exec_sva (.*);

// File: tb/test_complement_decrement_branch_exec.sv
`timescale 1ns/1ps
module test_complement_decrement_branch_exec;
  logic        mclk = 0, rst_n = 0, insn_valid = 0;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  file_rdata, file_wdata, acc_wdata, sh [128];
  logic [6:0]  file_addr;
  logic [11:0] pc_target;
  logic        file_we, acc_we, zero_flag, zero_we, pc_load, flush, busy;
  logic        unknown_insn;
  logic [33:0] notes [$];
  logic [5:0]  ops [3] = '{6'h09, 6'h03, 6'h0B};
  int          num_errors = 0, checks_done = 0, seed = 69858, r;
  initial forever #10 mclk = ~mclk;
  complement_decrement_branch_exec i_complement_decrement_branch_exec (.*);
  file_reg_model i_file_reg_model (.mclk(mclk), .raddr(insn[6:0]),
    .we(file_we), .waddr(file_addr), .wdata(file_wdata), .rdata(file_rdata));
  task automatic check(input string name, input logic [33:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic issue(input logic [13:0] w, input bit keep, gap);
    logic [7:0] res;
    logic       sk;
    res = w[13:8] == 6'h09 ? ~sh[w[6:0]] : sh[w[6:0]] - 8'h01;
    sk = w[13:8] == 6'h0B;
    @(negedge mclk);
    insn_valid = 1;
    insn = w;
    if (keep && w[13:12] == 2'h3) notes.push_back({7'h03, 15'h0, w[11:0]});
    else if (keep && w[13:8] inside {6'h09, 6'h03, 6'h0B}) begin
      notes.push_back({1'b0, !w[7], w[7], !sk, !sk && res == 0, 1'b0,
        sk && res == 0, w[7] ? w[6:0] : 7'h00, res, 12'h000});
      if (w[7]) sh[w[6:0]] = res;
    end else if (keep) notes.push_back({1'b1, 33'h0});
    if (gap) begin
      @(negedge mclk);
      insn_valid = 0;
    end
  endtask
  always @(negedge mclk) if (unknown_insn | acc_we | file_we | pc_load)
    check("outputs",
      {unknown_insn, acc_we, file_we, zero_we, zero_we & zero_flag,
      pc_load, flush, file_we ? file_addr : 7'h00, file_we ? file_wdata :
      acc_we ? acc_wdata : 8'h00, pc_load ? pc_target : 12'h000},
      notes.pop_front());
  initial begin
    #100us;
    num_errors++;
    give_verdict;
  end
  initial begin
    for (int i = 0; i < 128; i++) sh[i] = 8'(i);
    repeat (20) @(negedge mclk);
    rst_n = 1;
    issue(14'h0913, 1, 0);
    issue(14'h0381, 1, 0);
    issue(14'h0380, 1, 0);
    issue(14'h0B82, 1, 1);
    issue(14'h0B82, 1, 0);
    issue(14'h03FF, 0, 0);
    issue(14'h3123, 1, 0);
    issue(14'h0905, 0, 0);
    issue(14'h3FFF, 1, 1);
    issue(14'h0900, 1, 0);
    issue(14'h09FF, 1, 0);
    issue(14'h2000, 1, 1);
    $display("directed tests done");
    repeat (40) begin
      r = $random(seed);
      issue(r[9:8] == 2'h3 ? {2'h3, r[11:0]} : {ops[r[9:8]], r[7:0]}, 1, 1);
    end
    repeat (3) @(negedge mclk);
    check("pending notes", 34'(notes.size()), 34'h0);
    $display("random tests done");
    give_verdict;
  end
endmodule // test_complement_decrement_branch_exec
